// ### rtl/absolute_position_tracker.sv
`timescale 1ns/1ps
`default_nettype none
module absolute_position_tracker (
   input wire logic sys_clk,
   input wire logic rstn,
   // Encoder increments, already in the sys_clk domain
   input wire logic step_valid,
   input wire logic step_ccw,

   // Battery monitor and supply monitor pins
   input wire logic battery_low_pin,
   input wire logic mains_lost_unbacked_pin,

   // Configuration
   input wire logic coord_system_type_select,
   input wire logic [apt_pkg::OPT_W-1:0] overflow_and_unit_options,
   input wire logic direction_definition,
   input wire logic [apt_pkg::GEAR_W-1:0] gear_numerator,
   input wire logic [apt_pkg::GEAR_W-1:0] gear_denominator,
   input wire logic signed [apt_pkg::POS_W-1:0] origin_offset_value,
   input wire logic coord_init_trigger,

   // Results
   output logic signed [apt_pkg::TURN_W-1:0] turn_count_readout,
   output logic [apt_pkg::POS_W-1:0] single_turn_pulse_readout,
   output logic signed [apt_pkg::POS_W-1:0] user_unit_position,
   output logic position_valid,
   output logic coord_missing_alarm,
   output logic coord_unset_alarm,
   output logic low_battery_alarm,
   output logic turn_overflow_alarm,
   output logic user_unit_overflow_alarm
);
   // =======================================================
   // State record
   typedef struct packed {
      apt_pkg::calc_state_e calc;
      logic discard;
      logic signed [apt_pkg::TURN_W-1:0] turn;
      logic [apt_pkg::PULSE_W-1:0] pulse;
      logic established;
      logic calc_fresh;

      // Alarm flags
      logic missing;
      logic unset;
      logic low_batt;
      logic turn_ovf;
      logic uu_ovf;

      // Results
      logic signed [apt_pkg::POS_W-1:0] uu;
      logic signed [apt_pkg::TURN_W-1:0] turn_out;
      logic [apt_pkg::POS_W-1:0] readout;
      logic valid;
   } trk_s;

   trk_s st_reg;
   trk_s st_next;

   // =======================================================
   // Pin synchronisers
   logic batt_low;
   logic mains_lost;

   pin_sync u_sync_batt (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pin_in(battery_low_pin),
      .level(batt_low)
   );

   pin_sync u_sync_mains (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .pin_in(mains_lost_unbacked_pin),
      .level(mains_lost)
   );

   // =======================================================
   // Gear conversion datapath
   logic signed [apt_pkg::TOTAL_W-1:0] total_pulses;
   logic signed [apt_pkg::PROD_W-1:0] scaled;
   logic signed [apt_pkg::PROD_W-1:0] quot;
   logic signed [apt_pkg::PROD_W-1:0] term;
   logic signed [apt_pkg::PROD_W:0] uu_sum;
   logic uu_out_of_span;

   // Divider handshake
   logic div_start;
   logic div_busy;
   logic div_done;

   // Turns times 2^24 plus pulse is a plain concatenation
   assign total_pulses = {st_reg.turn, st_reg.pulse};

   // Full-width product so no gear setting can overflow it
   assign scaled = $signed({{(apt_pkg::PROD_W - apt_pkg::TOTAL_W)
                            {total_pulses[apt_pkg::TOTAL_W-1]}},
                           total_pulses})
                   * $signed({{(apt_pkg::PROD_W - apt_pkg::GEAR_W){1'b0}},
                              gear_denominator});

   gear_divider #(
      .DW(apt_pkg::PROD_W),
      .VW(apt_pkg::GEAR_W)
   ) u_div (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .start(div_start),
      .dividend(scaled),
      .divisor(gear_numerator),
      .busy(div_busy),
      .done(div_done),
      .quotient(quot)
   );

   // Clockwise definition negates the pulse term
   assign term = (direction_definition == apt_pkg::DIR_CW) ? -quot : quot;

   // Offset added at one bit more width to see leaving the span
   assign uu_sum = {term[apt_pkg::PROD_W-1], term}
                   + {{(apt_pkg::PROD_W + 1 - apt_pkg::POS_W)
                       {origin_offset_value[apt_pkg::POS_W-1]}},
                      origin_offset_value};

   // Upper bits must all copy the 32-bit sign bit
   assign uu_out_of_span =
      (uu_sum[apt_pkg::PROD_W:apt_pkg::POS_W-1] != '0) &&
      (uu_sum[apt_pkg::PROD_W:apt_pkg::POS_W-1] != '1);

   // Divider restarts only while idle; zero numerator means no update
   assign div_start = (st_reg.calc == apt_pkg::CALC_IDLE) && !div_busy
                      && (gear_numerator != '0);

   // =======================================================
   // Next-state logic
   logic absolute_mode;
   logic init_now;
   logic coord_lost;

   logic wrap_up;
   logic wrap_down;

   logic ign_turn;
   logic ign_uu;

   always_comb begin
      st_next = st_reg;

      absolute_mode =
         (coord_system_type_select == apt_pkg::COORD_ABSOLUTE);

      ign_turn = overflow_and_unit_options[apt_pkg::OPT_IGN_TURN_OVF];
      ign_uu = overflow_and_unit_options[apt_pkg::OPT_IGN_UU_OVF];

      // Initialisation is meaningful only in the absolute system
      init_now = coord_init_trigger && absolute_mode;

      // Loss of backup power drops the coordinate system
      coord_lost = absolute_mode && (batt_low || mains_lost);

      wrap_up = 1'b0;
      wrap_down = 1'b0;

      // Encoder stepping: single turn then rotation count
      if (step_valid) begin
         if (step_ccw) begin
            // Counterclockwise counts up
            if (st_reg.pulse == apt_pkg::PULSE_MAX) begin
               st_next.pulse = apt_pkg::PULSE_RST;
               if (st_reg.turn == apt_pkg::TURN_MAX) begin
                  st_next.turn = apt_pkg::TURN_MIN;
                  wrap_up = 1'b1;
               end else begin
                  st_next.turn = st_reg.turn + 16'sh0001;
               end
            end else begin
               st_next.pulse = st_reg.pulse + 24'h000001;
            end
         end else begin
            // Clockwise counts down
            if (st_reg.pulse == apt_pkg::PULSE_RST) begin
               st_next.pulse = apt_pkg::PULSE_MAX;
               if (st_reg.turn == apt_pkg::TURN_MIN) begin
                  st_next.turn = apt_pkg::TURN_MAX;
                  wrap_down = 1'b1;
               end else begin
                  st_next.turn = st_reg.turn - 16'sh0001;
               end
            end else begin
               st_next.pulse = st_reg.pulse - 24'h000001;
            end
         end
      end

      // Initialisation zeroes the pulse position; a step in the same
      // cycle is dropped since the new origin is where the shaft is
      if (init_now) begin
         st_next.turn = apt_pkg::TURN_RST;
         st_next.pulse = apt_pkg::PULSE_RST;
         st_next.uu = origin_offset_value;

         st_next.established = 1'b1;
         st_next.calc_fresh = 1'b1;

         st_next.turn_ovf = 1'b0;
         st_next.uu_ovf = 1'b0;
         st_next.missing = 1'b0;
         st_next.unset = 1'b0;
         // A result in flight or starting now predates the new origin
         if (st_reg.calc == apt_pkg::CALC_WAIT || div_start) begin
            st_next.discard = 1'b1;
         end
      end

      // Turn overflow latches unless ignored; wrap itself is silent
      if ((wrap_up || wrap_down) && absolute_mode && !ign_turn
          && !init_now) begin
         st_next.turn_ovf = 1'b1;
      end

      // Coordinate loss wins over an initialisation in the same cycle
      if (coord_lost) begin
         st_next.established = 1'b0;
         if (st_reg.established) begin
            st_next.unset = 1'b1;
         end
      end

      // Absolute system without coordinates raises the alarm
      if (absolute_mode && !st_next.established) begin
         st_next.missing = 1'b1;
      end
      if (!absolute_mode) begin
         st_next.missing = 1'b0;
         st_next.unset = 1'b0;
      end

      // Battery alarm follows the filtered monitor level
      st_next.low_batt = batt_low;

      // Conversion sequencer
      unique case (st_reg.calc)
         apt_pkg::CALC_IDLE: begin
            if (div_start) begin
               st_next.calc = apt_pkg::CALC_WAIT;
            end
         end

         apt_pkg::CALC_WAIT: begin
            if (div_done) begin
               st_next.calc = apt_pkg::CALC_IDLE;
               st_next.discard = 1'b0;
               if (!st_reg.discard && !init_now) begin
                  // Low 32 bits give the documented wrap
                  st_next.uu = uu_sum[apt_pkg::POS_W-1:0];
                  st_next.calc_fresh = 1'b1;
                  if (uu_out_of_span && absolute_mode && !ign_uu) begin
                     st_next.uu_ovf = 1'b1;
                  end
               end
            end
         end
      endcase

      // Readout registers
      st_next.turn_out = st_next.turn;

      // Pulse or user-unit word
      if (overflow_and_unit_options[apt_pkg::OPT_UNIT_PULSE]) begin
         st_next.readout = {8'h00, st_next.pulse};
      end else begin
         st_next.readout = st_next.uu;
      end

      // Invalid until a conversion or initialisation landed and, in the absolute system, coordinates exist, and while an overflow alarm stands
      st_next.valid = st_next.calc_fresh &&
                      (!absolute_mode || st_next.established) &&
                      !st_next.turn_ovf && !st_next.uu_ovf;
      if (coord_lost) begin
         st_next.calc_fresh = 1'b0;
      end
   end

   // =======================================================
   // State register
   // Reset leaves no coordinates set
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '{calc: apt_pkg::CALC_IDLE,
                     discard: 1'b0,
                     turn: apt_pkg::TURN_RST,
                     pulse: apt_pkg::PULSE_RST,
                     established: 1'b0,
                     calc_fresh: 1'b0,
                     missing: 1'b0,
                     unset: 1'b0,
                     low_batt: 1'b0,
                     turn_ovf: 1'b0,
                     uu_ovf: 1'b0,
                     uu: apt_pkg::POS_RST,
                     turn_out: apt_pkg::TURN_RST,
                     readout: apt_pkg::POS_RST,
                     valid: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   // =======================================================
   // Outputs, all straight from the state register
   assign turn_count_readout = st_reg.turn_out;
   assign single_turn_pulse_readout = st_reg.readout;
   assign user_unit_position = st_reg.uu;
   assign position_valid = st_reg.valid;

   // Alarm levels
   assign coord_missing_alarm = st_reg.missing;
   assign coord_unset_alarm = st_reg.unset;
   assign low_battery_alarm = st_reg.low_batt;
   assign turn_overflow_alarm = st_reg.turn_ovf;
   assign user_unit_overflow_alarm = st_reg.uu_ovf;
endmodule
`default_nettype wire

// ### include/apt_pkg.sv
`default_nettype none
// ==========================================================
// Shared constants of the absolute position tracker
package apt_pkg;
   // Field widths
   localparam int TURN_W = 16;
   localparam int PULSE_W = 24;
   localparam int TOTAL_W = 40;
   localparam int GEAR_W = 32;
   localparam int POS_W = 32;
   localparam int PROD_W = 73;
   localparam int SYNC_STAGES = 3;

   // Rotation count span and single-turn pulse span
   localparam logic signed [15:0] TURN_MAX = 16'sh7FFF;
   localparam logic signed [15:0] TURN_MIN = 16'sh8000;
   localparam logic signed [15:0] TURN_RST = 16'sh0000;
   localparam logic [23:0] PULSE_MAX = 24'hFFFFFF;
   localparam logic [23:0] PULSE_RST = 24'h000000;
   localparam logic [31:0] POS_RST = 32'h00000000;

   // Bit positions inside overflow_and_unit_options
   localparam int OPT_W = 3;
   localparam int OPT_IGN_TURN_OVF = 0;
   localparam int OPT_UNIT_PULSE = 1;
   localparam int OPT_IGN_UU_OVF = 2;

   // Selector and direction codes
   localparam logic COORD_INCREMENTAL = 1'b0;
   localparam logic COORD_ABSOLUTE = 1'b1;
   localparam logic DIR_CCW = 1'b0;
   localparam logic DIR_CW = 1'b1;

   // Conversion sequencer states
   typedef enum logic {
      CALC_IDLE = 1'b0,
      CALC_WAIT = 1'b1
   } calc_state_e;
endpackage
`default_nettype wire

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Three-stage pin synchroniser with agreement filter
module pin_sync (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic pin_in,
   output logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sync_s;

   sync_s st_reg;
   sync_s st_next;

   // First stage feeds only the second; change taken when 2 and 3 agree
   always_comb begin
      st_next = st_reg;
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      if (st_reg.s2 == st_reg.s3) begin
         st_next.lvl = st_reg.s3;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level = st_reg.lvl;
endmodule
`default_nettype wire

// ### rtl/gear_divider.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Sequential signed-by-unsigned restoring divider
module gear_divider #(
   parameter int DW = 73,
   parameter int VW = 32
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic signed [DW-1:0] dividend,
   input wire logic [VW-1:0] divisor,
   output logic busy,
   output logic done,
   output logic signed [DW-1:0] quotient
);
   localparam int CW = $clog2(DW + 1);

   if (DW < 2 || VW < 1 || VW >= DW) begin : g_bad_width
      $error("gear_divider: unsupported widths");
   end

   typedef struct packed {
      logic busy;
      logic done;
      logic neg;
      logic [CW-1:0] cnt;
      logic [VW:0] rem;
      logic [DW-1:0] quo;
      logic [VW-1:0] dv;
   } div_s;

   div_s st_reg;
   div_s st_next;
   logic [VW:0] rem_sh;
   logic take;

   // One quotient bit per cycle; sign restored at the end
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      rem_sh = {st_reg.rem[VW-1:0], st_reg.quo[DW-1]};
      take = (rem_sh >= {1'b0, st_reg.dv});
      if (!st_reg.busy) begin
         if (start) begin
            st_next.busy = 1'b1;
            st_next.neg = dividend[DW-1];
            st_next.quo = dividend[DW-1] ? -dividend : dividend;
            st_next.rem = '0;
            st_next.dv = divisor;
            st_next.cnt = CW'(DW);
         end
      end else if (st_reg.cnt != '0) begin
         st_next.rem = take ? rem_sh - {1'b0, st_reg.dv} : rem_sh;
         st_next.quo = {st_reg.quo[DW-2:0], take};
         st_next.cnt = st_reg.cnt - 1'b1;
      end else begin
         st_next.busy = 1'b0;
         st_next.done = 1'b1;
         st_next.quo = st_reg.neg ? -st_reg.quo : st_reg.quo;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign busy = st_reg.busy;
   assign done = st_reg.done;
   assign quotient = st_reg.quo;
endmodule
`default_nettype wire

// ### dv/apt_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port-level checks of the position tracker
module apt_checker (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic step_valid,
   input wire logic step_ccw,
   input wire logic battery_low_pin,
   input wire logic mains_lost_unbacked_pin,
   input wire logic coord_system_type_select,
   input wire logic [apt_pkg::OPT_W-1:0] overflow_and_unit_options,
   input wire logic signed [apt_pkg::POS_W-1:0] origin_offset_value,
   input wire logic coord_init_trigger,
   input wire logic signed [apt_pkg::TURN_W-1:0] turn_count_readout,
   input wire logic [apt_pkg::POS_W-1:0] single_turn_pulse_readout,
   input wire logic signed [apt_pkg::POS_W-1:0] user_unit_position,
   input wire logic position_valid,
   input wire logic coord_missing_alarm,
   input wire logic low_battery_alarm,
   input wire logic turn_overflow_alarm,
   input wire logic user_unit_overflow_alarm
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic [2:0] quiet_reg;
   logic opt_pulse;
   logic ign_uu;
   logic ign_turn;
   logic [23:0] pulse_lo;
   logic sel;
   // Option bits and the single-turn field, split out for $past
   assign opt_pulse = overflow_and_unit_options[apt_pkg::OPT_UNIT_PULSE];
   assign ign_uu = overflow_and_unit_options[apt_pkg::OPT_IGN_UU_OVF];
   assign ign_turn = overflow_and_unit_options[apt_pkg::OPT_IGN_TURN_OVF];
   assign pulse_lo = single_turn_pulse_readout[23:0];
   assign sel = coord_system_type_select;
   // Quiet time of the loss pins, since the pin synchroniser lags
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         quiet_reg <= 3'h0;
      end else if (battery_low_pin || mains_lost_unbacked_pin) begin
         quiet_reg <= 3'h0;
      end else if (quiet_reg != 3'h7) begin
         quiet_reg <= quiet_reg + 3'h1;
      end
   end
   // ==========================================================
   // Properties
   property p_pulse_step;
      step_valid && !coord_init_trigger && opt_pulse && $past(opt_pulse)
      |=> pulse_lo == $past(pulse_lo) +
         ($past(step_ccw) ? 24'h000001 : 24'hFFFFFF);
   endproperty
   a_pulse_step: assert property (p_pulse_step)
      else $error("single-turn count missed a step");
   property p_turn_carry;
      step_valid && !coord_init_trigger && opt_pulse && $past(opt_pulse)
      && pulse_lo == (step_ccw ? 24'hFFFFFF : 24'h000000)
      |=> turn_count_readout == $past(turn_count_readout) +
         ($past(step_ccw) ? 16'sh0001 : 16'shFFFF);
   endproperty
   a_turn_carry: assert property (p_turn_carry)
      else $error("turn count missed a carry");
   property p_init;
      coord_init_trigger && sel && quiet_reg == 3'h7
      |=> turn_count_readout == 16'sh0000 && !coord_missing_alarm &&
         !turn_overflow_alarm &&
         user_unit_position == $past(origin_offset_value);
   endproperty
   a_init: assert property (p_init)
      else $error("initialisation result wrong");
   property p_batt;
      battery_low_pin [*7] |-> low_battery_alarm;
   endproperty
   a_batt: assert property (p_batt)
      else $error("low battery alarm missing");
   property p_loss;
      low_battery_alarm && sel && $past(sel) |-> ##[0:2] coord_missing_alarm;
   endproperty
   a_loss: assert property (p_loss)
      else $error("coordinates not lost on low battery");
   property p_invalid;
      coord_missing_alarm |-> !position_valid;
   endproperty
   a_invalid: assert property (p_invalid)
      else $error("position valid without coordinates");
   property p_incr;
      !sel && !$past(sel) |-> !coord_missing_alarm && !turn_overflow_alarm;
   endproperty
   a_incr: assert property (p_incr)
      else $error("absolute alarm in incremental mode");
   property p_uu_cause;
      $rose(user_unit_overflow_alarm) |-> !$past(ign_uu) && $past(sel);
   endproperty
   a_uu_cause: assert property (p_uu_cause)
      else $error("user-unit overflow alarm while ignored");
   property p_turn_cause;
      $rose(turn_overflow_alarm) |-> !$past(ign_turn) && $past(sel);
   endproperty
   a_turn_cause: assert property (p_turn_cause)
      else $error("turn overflow alarm while ignored");
   // Main scenarios reached
   c_init: cover property (coord_init_trigger && sel);
   c_batt: cover property ($rose(low_battery_alarm));
   c_uu: cover property ($rose(user_unit_overflow_alarm));
endmodule
bind absolute_position_tracker apt_checker u_apt_checker (.*);
`default_nettype wire

// ### dv/encoder_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Encoder side: emits a burst of one-count steps
module encoder_model (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic go,
   input wire logic [7:0] count,
   input wire logic ccw,
   input wire logic slow,
   output logic step_valid,
   output logic step_ccw,
   output logic busy
);
   logic [7:0] left_reg;
   logic dir_reg;
   // Slow mode leaves an idle cycle between steps
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         left_reg <= 8'h00;
         dir_reg <= 1'b0;
         step_valid <= 1'b0;
         step_ccw <= 1'b1;
      end else if (go) begin
         left_reg <= count;
         dir_reg <= ccw; // 1 counterclockwise, 0 clockwise
         step_valid <= 1'b0;
      end else if (left_reg != 8'h00 && !(slow && step_valid)) begin
         left_reg <= left_reg - 8'h01;
         step_valid <= 1'b1;
         step_ccw <= dir_reg;
      end else begin
         step_valid <= 1'b0;
         step_ccw <= ~step_ccw; // Idle direction is junk on purpose
      end
   end
   assign busy = left_reg != 8'h00 || step_valid;
endmodule
`default_nettype wire

// ### dv/absolute_position_tracker_tb.sv
`timescale 1ns/1ps
`default_nettype none
module absolute_position_tracker_tb;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic battery_low_pin = 1'b0;
   logic mains_lost_unbacked_pin = 1'b0;
   logic coord_system_type_select = 1'b1;
   logic [2:0] overflow_and_unit_options = 3'h0;
   logic direction_definition = 1'b0;
   logic [31:0] gear_numerator = 32'h00000001;
   logic [31:0] gear_denominator = 32'h00000001;
   logic signed [31:0] origin_offset_value = 32'sh00000005;
   logic coord_init_trigger = 1'b0;
   logic go = 1'b0;
   logic [7:0] count = 8'h00;
   logic ccw = 1'b0;
   logic slow = 1'b0;
   logic step_valid, step_ccw, busy, position_valid, coord_missing_alarm;
   logic coord_unset_alarm, low_battery_alarm, turn_overflow_alarm;
   logic user_unit_overflow_alarm;
   logic signed [15:0] turn_count_readout;
   logic [31:0] single_turn_pulse_readout;
   logic signed [31:0] user_unit_position;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   encoder_model u_encoder_model (.sys_clk(sys_clk), .rstn(rstn), .go(go),
      .count(count), .ccw(ccw), .slow(slow), .step_valid(step_valid),
      .step_ccw(step_ccw), .busy(busy));
   absolute_position_tracker u_absolute_position_tracker (
      .sys_clk(sys_clk), .rstn(rstn), .step_valid(step_valid),
      .step_ccw(step_ccw), .battery_low_pin(battery_low_pin),
      .mains_lost_unbacked_pin(mains_lost_unbacked_pin),
      .coord_system_type_select(coord_system_type_select),
      .overflow_and_unit_options(overflow_and_unit_options),
      .direction_definition(direction_definition),
      .gear_numerator(gear_numerator), .gear_denominator(gear_denominator),
      .origin_offset_value(origin_offset_value),
      .coord_init_trigger(coord_init_trigger),
      .turn_count_readout(turn_count_readout),
      .single_turn_pulse_readout(single_turn_pulse_readout),
      .user_unit_position(user_unit_position),
      .position_valid(position_valid),
      .coord_missing_alarm(coord_missing_alarm),
      .coord_unset_alarm(coord_unset_alarm),
      .low_battery_alarm(low_battery_alarm),
      .turn_overflow_alarm(turn_overflow_alarm),
      .user_unit_overflow_alarm(user_unit_overflow_alarm));
   // ==========================================================
   // Helpers
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %b", $time, m, got);
      end
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
         input string m);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h", $time, m, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic pulse_init;
      @(posedge sys_clk);
      coord_init_trigger <= 1'b1;
      @(posedge sys_clk);
      coord_init_trigger <= 1'b0;
      #1;
   endtask
   task automatic steps(input logic [7:0] n, input logic d, input logic g);
      @(posedge sys_clk);
      go <= 1'b1;
      count <= n;
      ccw <= d;
      slow <= g;
      tick(1);
      go <= 1'b0;
      for (int i = 0; i < 100 && busy; i++) tick(1);
      tick(2);
   endtask
   // Conversion is long and may restart, so poll under a bound
   task automatic wait_uu(input logic [31:0] exp);
      for (int i = 0; i < 300 && user_unit_position !== exp; i++) tick(1);
      chk_word(user_unit_position, exp, "user units");
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_start;
      tick(2);
      chk_bit(coord_missing_alarm, 1'b1, "missing at start");
      chk_bit(position_valid, 1'b0, "valid at start");
      pulse_init;
      chk_word(32'(turn_count_readout), 32'h0, "turn after init");
      chk_word(user_unit_position, 32'h5, "uu after init");
      chk_bit(coord_missing_alarm, 1'b0, "missing cleared");
      for (int i = 0; i < 300 && !position_valid; i++) tick(1);
      chk_bit(position_valid, 1'b1, "valid after init");
      $display("test start done");
   endtask
   task automatic t_steps;
      @(posedge sys_clk);
      overflow_and_unit_options <= 3'h2;
      steps(8'h03, 1'b0, 1'b0);
      chk_word(single_turn_pulse_readout, 32'h00FFFFFD, "pulse cw");
      chk_word(32'(turn_count_readout), 32'hFFFFFFFF, "turn cw");
      @(posedge sys_clk);
      overflow_and_unit_options <= 3'h0;
      gear_numerator <= 32'h00000002;
      gear_denominator <= 32'h00000004;
      wait_uu(32'hFFFFFFFF);
      chk_word(single_turn_pulse_readout, 32'hFFFFFFFF, "units");
      direction_definition <= 1'b1;
      wait_uu(32'h0000000B);
      direction_definition <= 1'b0;
      overflow_and_unit_options <= 3'h2;
      steps(8'h04, 1'b1, 1'b1);
      chk_word(single_turn_pulse_readout, 32'h00000001, "pulse ccw");
      chk_word(32'(turn_count_readout), 32'h0, "turn ccw");
      $display("test steps done");
   endtask
   task automatic t_uu_ovf;
      for (int k = 0; k < 2; k++) begin
         @(posedge sys_clk);
         overflow_and_unit_options <= (k == 0) ? 3'h0 : 3'h5;
         gear_numerator <= 32'h00000001;
         gear_denominator <= 32'h7FFFFFFF;
         origin_offset_value <= 32'sh00000001;
         pulse_init;
         steps(8'h01, 1'b1, 1'b0);
         wait_uu(32'h80000000);
         tick(2);
         chk_bit(user_unit_overflow_alarm, k == 0, "uu alarm");
      end
      $display("test overflow done");
   endtask
   task automatic t_loss;
      @(posedge sys_clk);
      battery_low_pin <= 1'b1;
      tick(8);
      chk_bit(low_battery_alarm, 1'b1, "battery alarm");
      chk_bit(coord_missing_alarm, 1'b1, "lost on battery");
      pulse_init;
      chk_bit(coord_missing_alarm, 1'b1, "init under loss");
      battery_low_pin <= 1'b0;
      tick(8);
      chk_bit(low_battery_alarm, 1'b0, "battery recovered");
      pulse_init;
      mains_lost_unbacked_pin <= 1'b1;
      tick(8);
      chk_bit(coord_missing_alarm, 1'b1, "lost on mains");
      chk_bit(coord_unset_alarm, 1'b1, "unset on mains");
      mains_lost_unbacked_pin <= 1'b0;
      tick(8);
      pulse_init;
      chk_bit(coord_missing_alarm, 1'b0, "missing cleared");
      chk_bit(coord_unset_alarm, 1'b0, "unset cleared");
      $display("test loss done");
   endtask
   task automatic t_incr;
      steps(8'h01, 1'b0, 1'b0);
      coord_system_type_select <= 1'b0;
      tick(3);
      chk_bit(coord_missing_alarm, 1'b0, "incremental alarm");
      pulse_init;
      chk_word(32'(turn_count_readout), 32'hFFFFFFFF, "init ignored");
      coord_system_type_select <= 1'b1;
      tick(2);
      pulse_init;
      chk_word(32'(turn_count_readout), 32'h0, "init absolute");
      $display("test incremental done");
   endtask
   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("wrong value at %0t: run hung", $time);
         complete_run;
      end
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      t_start;
      t_steps;
      t_uu_ovf;
      t_loss;
      t_incr;
      complete_run;
   end
endmodule
`default_nettype wire
